// >>> logic/tlic_pkg.sv
// Notes on behaviour
// - two levels per source; low never preempts a running high-level routine
// - same-level ties go by fixed order ext0 first, watchdog last
// - flags sampled, polled and resolved every machine cycle
// - no call while equal or higher level is in service
// - call only when polling meets the final cycle of the instruction
// - no call while instruction writes enable/priority registers or is return-from-irq
// - refused requests are not remembered; each poll starts fresh
// - timer 0 and 1 overflow flags cleared on vectoring to them
// - ext 0 and 1 flags cleared on vectoring only in edge mode
// - serial, timer 2, power-fail and watchdog flags left for software
// - call pushes the program counter, not the status word, then loads vector
// - fixed vector address per source
// - return-from-irq ends in-service; plain return leaves it set
// - ext pins 0..5 sampled and flags updated at the third clock phase
// - timer 0/1 flags set at third phase, polled in next machine cycle
// - call lasts four machine cycles; five cycles minimum flag to routine
// - worst response twelve machine cycles with nothing else in service
// - global enable masks all but power-fail; per-source enables gate each
// - edge mode sets flag on high sample followed by low sample
// - ext 2..5 flags hardware-cleared on entry only when clear enable set
package tlic_pkg;
	// ==========================================
	// machine cycle timing
	localparam int TLIC_CLK_PERIOD_NS = 10;
	localparam int TLIC_CLKS_PER_MCYC = 4;
	localparam int TLIC_CALL_MCYC = 4;
	localparam int TLIC_MAX_LATENCY_MCYC = 12;
	localparam int TLIC_CALL_CLKS = TLIC_CALL_MCYC * TLIC_CLKS_PER_MCYC;
	localparam logic [1:0] TLIC_PH_C1 = 2'h0;
	localparam logic [1:0] TLIC_PH_C3 = 2'h2;
	localparam logic [3:0] TLIC_CALL_LAST = 4'(TLIC_CALL_CLKS - 1);

	// ==========================================
	// sources, in fixed order
	localparam int TLIC_NSRC = 12;
	localparam int TLIC_NEXT = 6;
	localparam logic [3:0] TLIC_SRC_EXT0 = 4'h0;
	localparam logic [3:0] TLIC_SRC_T0 = 4'h1;
	localparam logic [3:0] TLIC_SRC_EXT1 = 4'h2;
	localparam logic [3:0] TLIC_SRC_T1 = 4'h3;
	localparam logic [3:0] TLIC_SRC_EXT2 = 4'h7;
	localparam logic [3:0] TLIC_SRC_WD = 4'hb;
	localparam logic [15:0] TLIC_VEC [TLIC_NSRC] = '{
		16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023, 16'h002b,
		16'h003b, 16'h0043, 16'h004b, 16'h0053, 16'h005b, 16'h0063};

	// ==========================================
	// register indices and fields
	localparam logic [3:0] TLIC_REG_ENABLE_LOW = 4'h0;
	localparam logic [3:0] TLIC_REG_PRIORITY_LOW = 4'h1;
	localparam logic [3:0] TLIC_REG_ENABLE_EXT = 4'h2;
	localparam logic [3:0] TLIC_REG_PRIORITY_EXT = 4'h3;
	localparam logic [3:0] TLIC_REG_EXT_CONTROL = 4'h4;
	localparam logic [3:0] TLIC_REG_FLAGS = 4'h5;
	localparam logic [3:0] TLIC_REG_STATUS = 4'h6;
	localparam int TLIC_GLOBAL_BIT = 7;
	localparam int TLIC_FLAG_T0_BIT = 6;
	localparam int TLIC_FLAG_T1_BIT = 7;
	localparam logic [7:0] TLIC_RST_BYTE = 8'h00;

	// ==========================================
	// carriers
	typedef struct packed {
		logic last_cycle;
		logic cur_is_return_from_irq;
		logic return_from_irq_exec;
	} tlic_seq_s;

	typedef struct packed {
		logic t0_ovf;
		logic t1_ovf;
		logic ser0_rx;
		logic ser0_tx;
		logic ser1_rx;
		logic ser1_tx;
		logic t2_ovf;
		logic t2_ext;
		logic wd;
		logic power_fail_irq;
	} tlic_periph_s;

	typedef enum logic {
		TLIC_IDLE = 1'b0,
		TLIC_CALL = 1'b1
	} tlic_call_e;
endpackage

// >>> logic/tlic_pick.sv
`timescale 1ns/100ps
`default_nettype none
module tlic_pick import tlic_pkg::*; (
	input wire logic [TLIC_NSRC-1:0] req,
	output logic any,
	output logic [3:0] idx
);
	logic [TLIC_NSRC-1:0] first;

	// ==========================================
	// lowest index wins
	assign first[0] = req[0];
	genvar gi;
	generate
		for (gi = 1; gi < TLIC_NSRC; gi++) begin : g_first
			assign first[gi] = req[gi] & ~(|req[gi-1:0]);
		end
	endgenerate

	assign any = |req;

	always_comb begin
		idx = 4'h0;
		for (int i = 0; i < TLIC_NSRC; i++) begin
			if (first[i]) begin
				idx = 4'(i);
			end
		end
	end
endmodule
`default_nettype wire

// >>> logic/tlic_ctrl.sv
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/100ps
`default_nettype none
module tlic_ctrl import tlic_pkg::*; (
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [TLIC_NEXT-1:0] ext_irq_pin_n,
	input wire tlic_periph_s periph,
	input wire tlic_seq_s seq,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata_q,
	output logic call_start_q,
	output logic [15:0] call_vector_q,
	output logic call_active_q,
	output logic vector_load_q,
	output logic [1:0] in_service_q
);
	logic [TLIC_NEXT-1:0] pin_s1_q, pin_s2_q, samp_q, ext_flag_q, ext_clr_hw;
	logic [7:0] enable_mask_low_group_q, priority_select_low_group_q;
	logic [4:0] enable_mask_ext_group_q, priority_select_ext_group_q;
	logic [1:0] edge_mode_q;
	logic [3:0] hw_clear_enable_q;
	logic [1:0] phase_q;
	logic t0_pend_q, t1_pend_q, timer0_overflow_flag_q, timer1_overflow_flag_q;
	logic wr_seen_q;
	logic [3:0] cnt_q;
	tlic_call_e state_q;
	logic [TLIC_NSRC-1:0] src_flag, src_en, src_pri, src_gate, req, req_hi, req_lo;
	logic hi_any, lo_any, allow, withhold, decide, at_c3, at_c1;
	logic [3:0] hi_idx, lo_idx, win_idx;
	logic wr_flags;
	localparam int CALL_CLKS = TLIC_CALL_CLKS;

	function automatic logic [3:0] src_index(input int e);
		if (e < 2) begin
			src_index = e == 0 ? TLIC_SRC_EXT0 : TLIC_SRC_EXT1;
		end else begin
			src_index = TLIC_SRC_EXT2 + 4'(e - 2);
		end
	endfunction

	// ==========================================
	// machine cycle phase
	always_ff @(posedge mclk) begin
		if (rst) begin
			phase_q <= TLIC_PH_C1;
		end else if (ce) begin
			phase_q <= phase_q + 2'h1;
		end
	end
	assign at_c3 = ce && phase_q == TLIC_PH_C3;
	assign at_c1 = ce && phase_q == TLIC_PH_C1;

	// ==========================================
	// pin synchroniser
	always_ff @(posedge mclk) begin
		if (rst) begin
			pin_s1_q <= '1;
			pin_s2_q <= '1;
		end else if (ce) begin
			pin_s1_q <= ext_irq_pin_n;
			pin_s2_q <= pin_s1_q;
		end
	end

	// ==========================================
	// external request flags
	assign wr_flags = ce && reg_wr && reg_addr == TLIC_REG_FLAGS;

	always_ff @(posedge mclk) begin
		if (rst) begin
			samp_q <= '1;
		end else if (at_c3) begin
			samp_q <= pin_s2_q;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < TLIC_NEXT; gi++) begin : g_ext
			logic lvl_mode, fall, clr;
			if (gi < 2) begin : g_sel
				assign lvl_mode = ~edge_mode_q[gi];
				assign ext_clr_hw[gi] = edge_mode_q[gi];
			end else begin : g_sel
				assign lvl_mode = 1'b0;
				assign ext_clr_hw[gi] = hw_clear_enable_q[gi-2];
			end
			assign fall = samp_q[gi] & ~pin_s2_q[gi];
			assign clr = (wr_flags && reg_wdata[gi])
				|| (decide && ext_clr_hw[gi] && win_idx == src_index(gi));
			always_ff @(posedge mclk) begin
				if (rst) begin
					ext_flag_q[gi] <= 1'b0;
				end else if (at_c3 && lvl_mode) begin
					ext_flag_q[gi] <= ~pin_s2_q[gi];
				end else if (at_c3 && fall) begin
					ext_flag_q[gi] <= 1'b1;
				end else if (clr) begin
					ext_flag_q[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	// ==========================================
	// timer overflow flags
	always_ff @(posedge mclk) begin
		if (rst) begin
			t0_pend_q <= 1'b0;
			t1_pend_q <= 1'b0;
			timer0_overflow_flag_q <= 1'b0;
			timer1_overflow_flag_q <= 1'b0;
		end else if (ce) begin
			// overflow pulses wait for the third phase so polling sees them a cycle later
			t0_pend_q <= (t0_pend_q | periph.t0_ovf) & ~at_c3;
			t1_pend_q <= (t1_pend_q | periph.t1_ovf) & ~at_c3;
			if (at_c3 && (t0_pend_q || periph.t0_ovf)) begin
				timer0_overflow_flag_q <= 1'b1;
			end else if ((decide && win_idx == TLIC_SRC_T0)
				|| (wr_flags && reg_wdata[TLIC_FLAG_T0_BIT])) begin
				timer0_overflow_flag_q <= 1'b0;
			end
			if (at_c3 && (t1_pend_q || periph.t1_ovf)) begin
				timer1_overflow_flag_q <= 1'b1;
			end else if ((decide && win_idx == TLIC_SRC_T1)
				|| (wr_flags && reg_wdata[TLIC_FLAG_T1_BIT])) begin
				timer1_overflow_flag_q <= 1'b0;
			end
		end
	end

	// ==========================================
	// request vector and resolution
	always_comb begin
		// serial, timer 2 and watchdog flags are owned outside, never cleared here
		src_flag = {periph.wd | periph.power_fail_irq, ext_flag_q[5:2],
			periph.ser1_rx | periph.ser1_tx, periph.t2_ovf | periph.t2_ext,
			periph.ser0_rx | periph.ser0_tx, timer1_overflow_flag_q, ext_flag_q[1],
			timer0_overflow_flag_q, ext_flag_q[0]};
		src_en = {enable_mask_ext_group_q, enable_mask_low_group_q[6:0]};
		src_pri = {priority_select_ext_group_q, priority_select_low_group_q[6:0]};
		src_gate = {TLIC_NSRC{enable_mask_low_group_q[TLIC_GLOBAL_BIT]}};
		src_gate[TLIC_SRC_WD] = enable_mask_low_group_q[TLIC_GLOBAL_BIT] | periph.power_fail_irq;
		req = src_flag & src_en & src_gate;
		req_hi = req & src_pri;
		req_lo = req & ~src_pri;
	end

	tlic_pick u_pick_hi (
		.req(req_hi),
		.any(hi_any),
		.idx(hi_idx)
	);

	tlic_pick u_pick_lo (
		.req(req_lo),
		.any(lo_any),
		.idx(lo_idx)
	);

	assign win_idx = hi_any ? hi_idx : lo_idx;
	assign allow = hi_any ? ~in_service_q[1] : (lo_any & ~(|in_service_q));
	assign withhold = wr_seen_q | seq.cur_is_return_from_irq;
	// polled fresh from live flags each cycle; nothing of a refused request is kept
	assign decide = at_c1 && state_q == TLIC_IDLE && allow && seq.last_cycle
		&& !withhold;

	// ==========================================
	// forced vector call
	always_ff @(posedge mclk) begin
		if (rst) begin
			state_q <= TLIC_IDLE;
			cnt_q <= 4'h0;
			call_start_q <= 1'b0;
			call_active_q <= 1'b0;
			vector_load_q <= 1'b0;
			call_vector_q <= 16'h0000;
		end else if (ce) begin
			call_start_q <= decide;
			vector_load_q <= 1'b0;
			unique case (state_q)
				TLIC_IDLE: begin
					cnt_q <= 4'h0;
					if (decide) begin
						state_q <= TLIC_CALL;
						call_active_q <= 1'b1;
						call_vector_q <= TLIC_VEC[win_idx];
					end
				end
				TLIC_CALL: begin
					cnt_q <= cnt_q + 4'h1;
					if (cnt_q == TLIC_CALL_LAST) begin
						state_q <= TLIC_IDLE;
						call_active_q <= 1'b0;
						vector_load_q <= 1'b1;
					end
				end
			endcase
		end
	end

	// ==========================================
	// in-service per level
	always_ff @(posedge mclk) begin
		if (rst) begin
			in_service_q <= 2'h0;
		end else if (ce) begin
			if (decide) begin
				in_service_q[hi_any] <= 1'b1;
			end else if (seq.return_from_irq_exec) begin
				// plain return has no port here, so it cannot end in-service
				if (in_service_q[1]) begin
					in_service_q[1] <= 1'b0;
				end else begin
					in_service_q[0] <= 1'b0;
				end
			end
		end
	end

	// ==========================================
	// register port
	always_ff @(posedge mclk) begin
		if (rst) begin
			enable_mask_low_group_q <= TLIC_RST_BYTE;
			priority_select_low_group_q <= TLIC_RST_BYTE;
			enable_mask_ext_group_q <= TLIC_RST_BYTE[4:0];
			priority_select_ext_group_q <= TLIC_RST_BYTE[4:0];
			edge_mode_q <= TLIC_RST_BYTE[1:0];
			hw_clear_enable_q <= TLIC_RST_BYTE[3:0];
		end else if (ce && reg_wr) begin
			unique case (reg_addr)
				TLIC_REG_ENABLE_LOW: enable_mask_low_group_q <= reg_wdata;
				TLIC_REG_PRIORITY_LOW: priority_select_low_group_q <= reg_wdata;
				TLIC_REG_ENABLE_EXT: enable_mask_ext_group_q <= reg_wdata[4:0];
				TLIC_REG_PRIORITY_EXT: priority_select_ext_group_q <= reg_wdata[4:0];
				TLIC_REG_EXT_CONTROL: begin
					edge_mode_q <= reg_wdata[1:0];
					hw_clear_enable_q <= reg_wdata[5:2];
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			wr_seen_q <= 1'b0;
		end else if (ce) begin
			// a write lands mid-instruction; hold it until the next poll has seen it
			if (reg_wr && reg_addr <= TLIC_REG_PRIORITY_EXT) begin
				wr_seen_q <= 1'b1;
			end else if (at_c1) begin
				wr_seen_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			reg_rdata_q <= TLIC_RST_BYTE;
		end else if (ce) begin
			reg_rdata_q <= TLIC_RST_BYTE;
			if (reg_rd) begin
				unique case (reg_addr)
					TLIC_REG_ENABLE_LOW: reg_rdata_q <= enable_mask_low_group_q;
					TLIC_REG_PRIORITY_LOW: reg_rdata_q <= priority_select_low_group_q;
					TLIC_REG_ENABLE_EXT: reg_rdata_q <= {3'h0, enable_mask_ext_group_q};
					TLIC_REG_PRIORITY_EXT: reg_rdata_q <= {3'h0, priority_select_ext_group_q};
					TLIC_REG_EXT_CONTROL: reg_rdata_q <= {2'h0, hw_clear_enable_q, edge_mode_q};
					TLIC_REG_FLAGS: reg_rdata_q <= {timer1_overflow_flag_q,
						timer0_overflow_flag_q, ext_flag_q};
					TLIC_REG_STATUS: reg_rdata_q <= {5'h00, call_active_q, in_service_q};
					default: reg_rdata_q <= TLIC_RST_BYTE;
				endcase
			end
		end
	end

	// ==========================================
	// checks
	property p_no_preempt;
		@(posedge mclk) disable iff (rst)
		call_start_q |-> !$past(in_service_q[1]);
	endproperty
	a_no_preempt: assert property (p_no_preempt) else $error("low call over high");

	property p_level_block;
		@(posedge mclk) disable iff (rst)
		decide |-> (hi_any ? !in_service_q[1] : !(|in_service_q));
	endproperty
	a_level_block: assert property (p_level_block) else $error("call while in service");

	property p_last_cycle;
		@(posedge mclk) disable iff (rst)
		call_start_q |-> $past(seq.last_cycle) && $past(phase_q) == TLIC_PH_C1;
	endproperty
	a_last_cycle: assert property (p_last_cycle) else $error("call off final cycle");

	property p_withhold;
		@(posedge mclk) disable iff (rst)
		call_start_q |-> !$past(wr_seen_q) && !$past(seq.cur_is_return_from_irq);
	endproperty
	a_withhold: assert property (p_withhold) else $error("call during register write");

	property p_no_memory;
		@(posedge mclk) disable iff (rst)
		call_start_q |-> $past(req[win_idx]);
	endproperty
	a_no_memory: assert property (p_no_memory) else $error("call without request");

	property p_call_len;
		@(posedge mclk) disable iff (rst || !ce)
		call_start_q |-> call_active_q ##CALL_CLKS vector_load_q && !call_active_q;
	endproperty
	a_call_len: assert property (p_call_len) else $error("call length wrong");

	property p_t0_clear;
		@(posedge mclk) disable iff (rst)
		call_start_q && call_vector_q == TLIC_VEC[TLIC_SRC_T0] |-> !timer0_overflow_flag_q;
	endproperty
	a_t0_clear: assert property (p_t0_clear) else $error("timer 0 flag kept");

	property p_return_from_irq_hi;
		@(posedge mclk) disable iff (rst || !ce)
		seq.return_from_irq_exec && !decide && in_service_q[1] |=> !in_service_q[1] && $stable(in_service_q[0]);
	endproperty
	a_return_from_irq_hi: assert property (p_return_from_irq_hi) else $error("return did not end high level");

	property p_ext_phase;
		@(posedge mclk) disable iff (rst)
		$rose(ext_flag_q[0]) |-> $past(phase_q) == TLIC_PH_C3;
	endproperty
	a_ext_phase: assert property (p_ext_phase) else $error("ext flag set off phase");
endmodule
`default_nettype wire

// >>> tb/tlic_seq_model.sv
`timescale 1ns/100ps
`default_nettype none
module tlic_seq_model import tlic_pkg::*; (
	input wire logic mclk,
	input wire logic rst,
	input wire logic last_in,
	input wire logic return_from_irq_in,
	input wire logic call_start_q,
	input wire logic vector_load_q,
	input wire logic [15:0] call_vector_q,
	output var tlic_seq_s seq,
	output logic [15:0] pc_q,
	output logic [1:0] depth_q
);
	// ==========================================
	// sequencer and stack
	logic return_from_irq_prev_q;
	logic [15:0] stack_q [4];
	always_comb begin
		seq.last_cycle = last_in;
		seq.cur_is_return_from_irq = return_from_irq_in;
		seq.return_from_irq_exec = return_from_irq_in & ~return_from_irq_prev_q;
	end
	always_ff @(posedge mclk) begin
		return_from_irq_prev_q <= rst ? 1'b0 : return_from_irq_in;
	end
	// pc only; status word never stacked, so depth counts pc pushes
	always_ff @(posedge mclk) begin
		if (rst) begin
			pc_q <= 16'h0100;
			depth_q <= 2'h0;
		end else if (call_start_q) begin
			stack_q[depth_q] <= pc_q;
			depth_q <= depth_q + 2'h1;
		end else if (vector_load_q) begin
			pc_q <= call_vector_q;
		end else if (seq.return_from_irq_exec && depth_q != 2'h0) begin
			pc_q <= stack_q[depth_q - 2'h1];
			depth_q <= depth_q - 2'h1;
		end
	end
endmodule
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb import tlic_pkg::*;;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic last_in = 1'b1;
	logic return_from_irq_in = 1'b0;
	logic [5:0] pins_n = 6'h3f;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	tlic_periph_s periph = '0;
	tlic_seq_s seq;
	logic [7:0] reg_rdata_q;
	logic call_start_q, call_active_q, vector_load_q;
	logic [15:0] call_vector_q, pc_q;
	logic [1:0] in_service_q, depth_q;
	int bad_count = 0;
	int checks = 0;

	tlic_ctrl i_tlic_ctrl (.mclk(mclk), .rst(rst), .ce(ce), .ext_irq_pin_n(pins_n),
		.periph(periph), .seq(seq), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
		.call_start_q(call_start_q), .call_vector_q(call_vector_q),
		.call_active_q(call_active_q), .vector_load_q(vector_load_q),
		.in_service_q(in_service_q));
	tlic_seq_model i_tlic_seq_model (.mclk(mclk), .rst(rst), .last_in(last_in),
		.return_from_irq_in(return_from_irq_in), .call_start_q(call_start_q), .vector_load_q(vector_load_q),
		.call_vector_q(call_vector_q), .seq(seq), .pc_q(pc_q), .depth_q(depth_q));

	initial begin
		forever #5 mclk = ~mclk;
	end

	// ==========================================
	// shared tasks
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp, input string what);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 chk(16'(reg_rdata_q), 16'(exp), what);
	endtask
	task automatic cfg(input logic [7:0] el, input logic [7:0] pl, input logic [7:0] ee,
		input logic [7:0] ctl);
		wr(TLIC_REG_ENABLE_LOW, el);
		wr(TLIC_REG_PRIORITY_LOW, pl);
		wr(TLIC_REG_ENABLE_EXT, ee);
		wr(TLIC_REG_PRIORITY_EXT, 8'h00);
		wr(TLIC_REG_EXT_CONTROL, ctl);
	endtask
	task automatic wait_call(input logic [15:0] vec, input logic [1:0] isr);
		int n;
		n = 0;
		do begin
			@(posedge mclk);
			#1 n++;
		end while (call_start_q !== 1'b1 && n < 48);
		chk(16'(n < 48), 16'h1, "call in time");
		chk(call_vector_q, vec, "vector");
		chk(16'(in_service_q), 16'(isr), "in service");
		n = 0;
		do begin
			@(posedge mclk);
			#1 n++;
		end while (vector_load_q !== 1'b1 && n < 40);
		chk(16'(n), 16'h10, "call length");
		@(posedge mclk);
		#1 chk(pc_q, vec, "pc loaded");
	endtask
	task automatic no_call(input int n, input string what);
		repeat (n) begin
			@(posedge mclk);
			#1 chk(16'(call_start_q), 16'h0, what);
		end
	endtask
	task automatic return_from_irq(input logic [1:0] isr);
		@(posedge mclk);
		return_from_irq_in <= 1'b1;
		@(posedge mclk);
		// looked at while the return still withholds, so a follow-on call cannot race it
		#1 chk(16'(in_service_q), 16'(isr), "after return");
		repeat (3) @(posedge mclk);
		return_from_irq_in <= 1'b0;
	endtask

	// ==========================================
	// scenarios
	task automatic t_regs();
		rd_chk(4'hf, 8'h00, "unmapped");
		wr(TLIC_REG_ENABLE_LOW, 8'h5a);
		rd_chk(TLIC_REG_ENABLE_LOW, 8'h5a, "enable readback");
		ce <= 1'b0;
		wr(TLIC_REG_ENABLE_LOW, 8'h33);
		ce <= 1'b1;
		rd_chk(TLIC_REG_ENABLE_LOW, 8'h5a, "frozen by enable");
		wr(TLIC_REG_STATUS, 8'hff);
		rd_chk(TLIC_REG_STATUS, 8'h00, "status idle");
		$display("test regs done");
	endtask
	task automatic t_ext0();
		cfg(8'h81, 8'h00, 8'h00, 8'h01);
		pins_n[0] <= 1'b0;
		wait_call(16'h0003, 2'b01);
		rd_chk(TLIC_REG_FLAGS, 8'h00, "edge flag cleared");
		pins_n[0] <= 1'b1;
		return_from_irq(2'b00);
		wr(TLIC_REG_EXT_CONTROL, 8'h00);
		pins_n[0] <= 1'b0;
		wait_call(16'h0003, 2'b01);
		rd_chk(TLIC_REG_FLAGS, 8'h01, "level flag kept");
		pins_n[0] <= 1'b1;
		repeat (10) @(posedge mclk);
		return_from_irq(2'b00);
		$display("test ext0 done");
	endtask
	task automatic t_order();
		cfg(8'h8a, 8'h00, 8'h00, 8'h00);
		periph.t0_ovf <= 1'b1;
		periph.t1_ovf <= 1'b1;
		@(posedge mclk);
		periph.t0_ovf <= 1'b0;
		periph.t1_ovf <= 1'b0;
		wait_call(16'h000b, 2'b01);
		rd_chk(TLIC_REG_FLAGS, 8'h80, "winner flag cleared");
		no_call(12, "equal level waits");
		return_from_irq(2'b00);
		wait_call(16'h001b, 2'b01);
		rd_chk(TLIC_REG_FLAGS, 8'h00, "timer1 flag cleared");
		return_from_irq(2'b00);
		$display("test order done");
	endtask
	task automatic t_preempt();
		cfg(8'h82, 8'h02, 8'h10, 8'h00);
		periph.wd <= 1'b1;
		wait_call(16'h0063, 2'b01);
		periph.t0_ovf <= 1'b1;
		@(posedge mclk);
		periph.t0_ovf <= 1'b0;
		wait_call(16'h000b, 2'b11);
		return_from_irq(2'b01);
		no_call(12, "low waits while low in service");
		return_from_irq(2'b00);
		wait_call(16'h0063, 2'b01);
		periph.wd <= 1'b0;
		return_from_irq(2'b00);
		$display("test preempt done");
	endtask
	task automatic t_block();
		cfg(8'h10, 8'h00, 8'h00, 8'h00);
		periph.ser0_rx <= 1'b1;
		no_call(16, "global off");
		last_in <= 1'b0;
		wr(TLIC_REG_ENABLE_LOW, 8'h90);
		no_call(16, "not last cycle");
		last_in <= 1'b1;
		return_from_irq_in <= 1'b1;
		no_call(16, "during return");
		last_in <= 1'b0;
		return_from_irq_in <= 1'b0;
		periph.ser0_rx <= 1'b0;
		repeat (4) @(posedge mclk);
		last_in <= 1'b1;
		no_call(16, "refused not remembered");
		periph.ser0_tx <= 1'b1;
		wait_call(16'h0023, 2'b01);
		periph.ser0_tx <= 1'b0;
		return_from_irq(2'b00);
		$display("test block done");
	endtask

	// ==========================================
	// run control
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		t_regs();
		t_ext0();
		t_order();
		t_preempt();
		t_block();
		report_and_stop();
	end
	// hangs are cut well beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge mclk);
		bad_count++;
		report_and_stop();
	end
endmodule
`default_nettype wire
